// >>> logic/oscd_top.sv
// Module: oscillator source selection, fast RC postscaler and processor clock reduction
`timescale 1ns/10ps
module oscd_top (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [3:0]   addr,
  input  wire logic [15:0]  wrData,
  input  wire logic         wrStb,
  input  wire logic         rdStb,
  output logic [15:0]       rdData,
  input  wire logic [2:0]   newSourceSelect,
  input  wire logic [1:0]   primarySourceMode,
  input  wire logic         oscPinFunctionFuse,
  input  wire logic         fusesErased,
  input  wire logic         fastRcTick,
  input  wire logic         lowPowerRcTick,
  input  wire logic         secondaryTick,
  input  wire logic         primaryTick,
  input  wire logic         interruptReq,
  output logic              oscTick,
  output logic              cycleTick,
  output logic              cpuTick,
  output logic              periphTick,
  output logic              pllActive,
  output logic              secondPinIsClock,
  output logic [2:0]        activeOscillator
);

  // ----------------------------------------------------------------
  // Input synchronisers for pin level oscillator ticks and fuses
  // ----------------------------------------------------------------
  logic [3:0]  tickMeta_q;
  logic [3:0]  tickSync_q;
  logic [3:0]  tickSeen_q;
  logic [6:0]  fuseMeta_q;
  logic [6:0]  fuseSync_q;
  logic        irqMeta_q;
  logic        irqSync_q;

  // Oscillators arrive from other domains; the first stage never feeds logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tickMeta_q <= 4'h0;
      tickSync_q <= 4'h0;
      tickSeen_q <= 4'h0;
      fuseMeta_q <= 7'h00;
      fuseSync_q <= 7'h00;
      irqMeta_q  <= 1'b0;
      irqSync_q  <= 1'b0;
    end else begin
      tickMeta_q <= {primaryTick, secondaryTick, lowPowerRcTick, fastRcTick};
      tickSync_q <= tickMeta_q;
      tickSeen_q <= tickSync_q;
      fuseMeta_q <= {fusesErased, oscPinFunctionFuse, primarySourceMode, newSourceSelect};
      fuseSync_q <= fuseMeta_q;
      irqMeta_q  <= interruptReq;
      irqSync_q  <= irqMeta_q;
    end
  end

  // Rising edge of each synchronised oscillator level is one source tick
  logic [3:0] srcEdge;
  logic       irqEdge;
  logic       irqSeen_q;
  assign srcEdge = tickSync_q & ~tickSeen_q;
  assign irqEdge = irqSync_q & ~irqSeen_q;

  // ----------------------------------------------------------------
  // Effective configuration, following the synchronised fuses every cycle
  // ----------------------------------------------------------------
  logic [2:0] srcSel;
  logic [1:0] priMode;
  logic       pinFuse;
  assign srcSel  = fuseSync_q[6] ? oscd_pkg::SRC_ERASED : fuseSync_q[2:0];  // see RQ6
  assign priMode = fuseSync_q[4:3];
  assign pinFuse = fuseSync_q[5];

  // ----------------------------------------------------------------
  // Clock divisor control register
  // ----------------------------------------------------------------
  logic       recover_q;
  logic [2:0] cpu_clock_reduction_ratio_q;
  logic       dozeEn_q;
  logic [2:0] post_q;
  logic       wrDiv;
  logic       wrDoze;
  logic       setDozeEn;
  logic       dozeEn_d;
  assign wrDiv     = wrStb && (addr == oscd_pkg::ADDR_DIVCTL);
  assign wrDoze    = wrDiv && !dozeEn_q;                                     // see RQ13
  assign setDozeEn = wrData[oscd_pkg::REDUCTION_ENABLE_BIT] && (cpu_clock_reduction_ratio_q != oscd_pkg::RATIO_ONE); // see RQ14
  // Interrupt recovery wins over a write in the same cycle, so no wake is lost
  assign dozeEn_d  = (recover_q && irqEdge) ? 1'b0 :                         // see RQ8
                     (wrDiv ? setDozeEn : dozeEn_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      recover_q <= 1'b0;
      cpu_clock_reduction_ratio_q    <= oscd_pkg::CPU_CLOCK_REDUCTION_RATIO_RST;                                       // see RQ9
      dozeEn_q  <= 1'b0;
      post_q    <= oscd_pkg::POST_RST;                                       // see RQ10
      irqSeen_q <= 1'b0;
    end else begin
      recover_q <= wrDiv ? wrData[oscd_pkg::RECOVER_BIT] : recover_q;
      cpu_clock_reduction_ratio_q    <= wrDoze ? wrData[oscd_pkg::CPU_CLOCK_REDUCTION_RATIO_LSB +: 3] : cpu_clock_reduction_ratio_q;
      dozeEn_q  <= dozeEn_d;
      post_q    <= wrDiv ? wrData[oscd_pkg::POST_LSB +: 3] : post_q;
      irqSeen_q <= irqSync_q;
    end
  end

  // ----------------------------------------------------------------
  // Source decode
  // ----------------------------------------------------------------
  logic [2:0] oscSel;
  logic       usePll;
  logic       usePost;
  logic       useDiv16;
  logic       extPinMode;
  // Mode field only matters for primary codes; internal codes ignore it
  assign oscSel = (srcSel == oscd_pkg::SRC_LOW_PWR) ? oscd_pkg::OSC_LOW_PWR : // see RQ3
                  (srcSel == oscd_pkg::SRC_SEC) ? oscd_pkg::OSC_SEC :        // see RQ4
                  (srcSel == oscd_pkg::SRC_PRI || srcSel == oscd_pkg::SRC_PRI_MUL) ?
                    oscd_pkg::OSC_PRI : oscd_pkg::OSC_FAST;                  // see RQ5
  assign usePll   = (srcSel == oscd_pkg::SRC_FAST_MUL) ||                    // see RQ1
                    (srcSel == oscd_pkg::SRC_PRI_MUL);
  assign usePost  = (srcSel == oscd_pkg::SRC_FAST_POST) ||
                    (srcSel == oscd_pkg::SRC_FAST_MUL);
  assign useDiv16 = (srcSel == oscd_pkg::SRC_FAST_D16);
  assign extPinMode = (oscSel != oscd_pkg::OSC_PRI) || (priMode == oscd_pkg::PM_EXT);

  // ----------------------------------------------------------------
  // Multiplier: four system ticks per source period
  // ----------------------------------------------------------------
  logic       srcTick;
  logic [1:0] burst_q;
  logic       pllTick;
  logic       postTick;
  logic [3:0] postShift;
  logic [3:0] postCodeShift;
  assign srcTick = srcEdge[oscSel[1:0]];
  // Codes divide by 2**code, except the top code, which skips 128 and goes to 256
  assign postCodeShift = (post_q == oscd_pkg::POST_TOP_CODE) ? oscd_pkg::POST_TOP_SHIFT :
                         {1'b0, post_q};                                     // see RQ10 RQ12
  // Fast RC postscaler or fixed divide-by-sixteen ahead of the multiplier
  assign postShift = useDiv16 ? oscd_pkg::SHIFT_DIV16 :
                     (usePost ? postCodeShift : oscd_pkg::SHIFT_NONE);       // see RQ10 RQ12

  oscd_pow2_divider #(.W(oscd_pkg::DIV_W)) uPost (
    .clk     (clk),
    .rst     (rst),
    .tickIn  (srcTick),
    .shift   (postShift),
    .tickOut (postTick)
  );

  // In multiplier modes each source tick is stretched to four system ticks; sources must stay below clk/4
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      burst_q <= 2'h0;
    end else begin
      burst_q <= (usePll && postTick) ? oscd_pkg::MUL_BURST :
                 (burst_q != 2'h0 ? burst_q - 2'h1 : 2'h0);
    end
  end
  assign pllTick = usePll ? (postTick || burst_q != 2'h0) : postTick;        // see RQ1

  // ----------------------------------------------------------------
  // Instruction rate and reduction
  // ----------------------------------------------------------------
  logic cycle_q;
  logic cycleNow;
  logic cpuNow;
  logic [3:0] dozeShift;
  assign cycleNow  = pllTick && cycle_q;                                     // see RQ2
  assign dozeShift = dozeEn_q ? {1'b0, cpu_clock_reduction_ratio_q} : oscd_pkg::SHIFT_NONE;       // see RQ11

  oscd_pow2_divider #(.W(oscd_pkg::DIV_W)) uDoze (
    .clk     (clk),
    .rst     (rst),
    .tickIn  (cycleNow),
    .shift   (dozeShift),                                                    // see RQ9
    .tickOut (cpuNow)
  );

  // Registered outputs; instruction tick is every second oscillator tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cycle_q          <= 1'b0;
      oscTick          <= 1'b0;
      cycleTick        <= 1'b0;
      cpuTick          <= 1'b0;
      periphTick       <= 1'b0;
      pllActive        <= 1'b0;
      secondPinIsClock <= 1'b0;
      activeOscillator <= oscd_pkg::OSC_NONE;
    end else begin
      cycle_q          <= pllTick ? !cycle_q : cycle_q;
      oscTick          <= pllTick;
      cycleTick        <= cycleNow;
      cpuTick          <= cpuNow;
      periphTick       <= cycleNow;
      pllActive        <= usePll;
      secondPinIsClock <= extPinMode ? pinFuse : 1'b1;                       // see RQ7
      activeOscillator <= oscSel;
    end
  end

  // ----------------------------------------------------------------
  // Read path, data valid the cycle after the strobe
  // ----------------------------------------------------------------
  logic [15:0] rdMux;
  assign rdMux = (addr == oscd_pkg::ADDR_DIVCTL) ?
                   {recover_q, cpu_clock_reduction_ratio_q, dozeEn_q, post_q, 8'h00} :
                 (addr == oscd_pkg::ADDR_CONFIG) ?
                   {8'h00, 1'b0, fuseSync_q[6:0]} :
                 (addr == oscd_pkg::ADDR_STATUS) ?
                   {11'h000, usePll, 1'b0, oscSel} : oscd_pkg::ZERO16;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= oscd_pkg::ZERO16;
    end else begin
      rdData <= rdStb ? rdMux : oscd_pkg::ZERO16;
    end
  end

endmodule

// >>> logic/oscd_pkg.sv
// Package: register map, field layout and mode encodings of the clock select and divider block
//
// Function
// RQ1: A multiplier mode multiplies the primary or fast RC oscillator by four to form the system clock.
// RQ2: The instruction rate is the system clock divided by two.
// RQ3: Source code 111 picks postscaled fast RC, 110 fast RC over sixteen, 101 low-power RC, mode field ignored.
// RQ4: Source code 100 picks the secondary oscillator, 001 postscaled fast RC with multiplier, 000 plain fast RC.
// RQ5: Source code 011 picks the primary oscillator through the multiplier, mode 01 crystal, 00 external clock.
// RQ6: An erased part starts in postscaled fast RC mode, source code 111.
// RQ7: In internal, secondary and external-clock modes a fuse decides whether the second crystal pin is a clock pin.
// RQ8: With recover-on-interrupt set, an interrupt clears the reduction enable and forces a 1:1 ratio.
// RQ9: The reduction field divides the instruction clock by two to its power, reset value 011.
// RQ10: The postscaler field divides fast RC by 256, 64, 32, 2, 1 for 111, 110, 101, 001, 000, reset 000.
// RQ11: Reduction enable set applies the reduction ratio; clear forces 1:1.
// RQ12: Postscaler codes 100, 011, 010 divide by 16, 8 and 4.
// RQ13: While reduction enable is set, writes to the reduction field are ignored.
// RQ14: While the reduction field holds 000, attempts to set reduction enable are ignored.
package oscd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 16;
  localparam logic [3:0]  ADDR_DIVCTL   = 4'h0;  // Clock divisor control
  localparam logic [3:0]  ADDR_CONFIG   = 4'h1;  // Fuse image, read only
  localparam logic [3:0]  ADDR_STATUS   = 4'h2;  // Live selection, read only

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          RECOVER_BIT   = 15;
  localparam int          CPU_CLOCK_REDUCTION_RATIO_LSB      = 12;
  localparam int          REDUCTION_ENABLE_BIT     = 11;
  localparam int          POST_LSB      = 8;
  localparam logic [2:0]  CPU_CLOCK_REDUCTION_RATIO_RST      = 3'h3;
  localparam logic [2:0]  POST_RST      = 3'h0;
  localparam logic [2:0]  RATIO_ONE     = 3'h0;
  localparam logic [3:0]  SHIFT_NONE    = 4'h0;  // Divide by one
  localparam logic [3:0]  SHIFT_DIV16   = 4'h4;  // Divide by sixteen
  localparam logic [2:0]  POST_TOP_CODE = 3'h7;  // Only postscaler code off the 2**code pattern
  localparam logic [3:0]  POST_TOP_SHIFT = 4'h8; // Divide by 256
  localparam logic [1:0]  MUL_BURST     = 2'h3;  // Extra ticks after the first, factor of four
  localparam logic [15:0] ZERO16        = 16'h0000;

  // ----------------------------------------------------------------
  // Source select and primary mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  SRC_FAST      = 3'h0;
  localparam logic [2:0]  SRC_FAST_MUL  = 3'h1;
  localparam logic [2:0]  SRC_PRI       = 3'h2;
  localparam logic [2:0]  SRC_PRI_MUL   = 3'h3;
  localparam logic [2:0]  SRC_SEC       = 3'h4;
  localparam logic [2:0]  SRC_LOW_PWR   = 3'h5;
  localparam logic [2:0]  SRC_FAST_D16  = 3'h6;
  localparam logic [2:0]  SRC_FAST_POST = 3'h7;
  localparam logic [2:0]  SRC_ERASED    = 3'h7;
  localparam logic [1:0]  PM_EXT        = 2'h0;
  localparam logic [1:0]  PM_MED        = 2'h1;
  localparam logic [1:0]  PM_HIGH       = 2'h2;
  localparam logic [2:0]  OSC_FAST      = 3'h0;  // Oscillator select indices
  localparam logic [2:0]  OSC_LOW_PWR   = 3'h1;
  localparam logic [2:0]  OSC_SEC       = 3'h2;
  localparam logic [2:0]  OSC_PRI       = 3'h3;
  localparam logic [2:0]  OSC_NONE      = 3'h4;

  // Divider of a power-of-two ratio given as shift
  localparam int          DIV_W         = 8;

endpackage

// >>> logic/oscd_pow2_divider.sv
// Module: power-of-two clock enable divider, emits a pulse every 2**shift input ticks
`timescale 1ns/10ps
module oscd_pow2_divider #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         tickIn,
  input  wire logic [3:0]   shift,
  output logic              tickOut
);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic [W-1:0] limit;
  logic         wrap;

  // Largest shift is eight, so the counter must hold 255
  if (W < 8) begin : g_widthCheck
    $error("oscd_pow2_divider: W must hold 2**8-1");
  end

  // Terminal count is 2**shift-1; shift zero passes every tick
  assign limit   = W'((1 << shift) - 1);
  assign wrap    = tickIn && (count_q >= limit);
  assign count_d = !tickIn ? count_q : (wrap ? '0 : count_q + W'(1));

  // Output is registered, so it follows the input tick by one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      tickOut <= 1'b0;
    end else begin
      count_q <= count_d;
      tickOut <= wrap;
    end
  end

endmodule

// >>> tb/oscd_checker_assertions.sv
// Checker: port timing relations of the clock select and divider block
`timescale 1ns/10ps
module oscd_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        rdStb,
  input wire logic [15:0] rdData,
  input wire logic        fusesErased,
  input wire logic        oscTick,
  input wire logic        cycleTick,
  input wire logic        cpuTick,
  input wire logic        periphTick,
  input wire logic        pllActive,
  input wire logic [2:0]  activeOscillator
);
  // ----------------------------------------------------------------
  // Oscillator ticks seen since the last instruction tick
  // ----------------------------------------------------------------
  logic [1:0] oscCnt_q;
  // Saturates at 3 so that an overrun stays visible
  always_ff @(posedge clk or posedge rst) begin
    if (rst) oscCnt_q <= 2'h0;
    else if (cycleTick) oscCnt_q <= 2'h0;
    else if (oscTick && oscCnt_q != 2'h3) oscCnt_q <= oscCnt_q + 2'h1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // One multiplied source tick: four pulses back to back, then a gap
  sequence burstOfFour;
    oscTick [*4] ##1 !oscTick;
  endsequence

  a_read_slot_only: assert property (rdData != 16'h0000 |-> $past(rdStb))
    else $error("read data outside its slot");
  a_periph_is_cycle: assert property (periphTick == cycleTick)
    else $error("peripheral tick differs from instruction tick");
  a_cpu_after_cycle: assert property (cpuTick |-> $past(cycleTick))
    else $error("processor tick without instruction tick");
  a_half_rate_max: assert property (oscCnt_q <= 2'h1)
    else $error("instruction tick missing on second oscillator tick");
  a_half_rate_min: assert property (cycleTick |-> oscCnt_q != 2'h0)
    else $error("instruction tick without oscillator ticks");
  a_pll_burst: assert property ($rose(oscTick) && pllActive |-> burstOfFour)
    else $error("multiplier burst is not four ticks");
  a_single_tick: assert property (oscTick && !pllActive && !$past(pllActive) |=> !oscTick)
    else $error("repeated tick without multiplier");
  a_erased_default: assert property (fusesErased && activeOscillator != 3'h4
    |-> activeOscillator == 3'h0 && !pllActive)
    else $error("erased part not on fast RC");
endmodule

bind oscd_top oscd_checker u_chk (.clk(clk), .rst(rst), .rdStb(rdStb), .rdData(rdData),
  .fusesErased(fusesErased), .oscTick(oscTick), .cycleTick(cycleTick), .cpuTick(cpuTick),
  .periphTick(periphTick), .pllActive(pllActive), .activeOscillator(activeOscillator));

// >>> tb/tb.sv
// Testbench: registers, source selection and divider rates of the clock block
`timescale 1ns/10ps
module tb;
  logic        clk = 1'b0, rst = 1'b1, wrStb = 1'b0, rdStb = 1'b0, rdPend = 1'b0;
  logic        pinFuse = 1'b0, erased = 1'b0, irq = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wrData = 16'h0000, rdData, expQ[$];
  logic [2:0]  src = 3'h0, actOsc;
  logic [1:0]  pm = 2'h1;
  logic [6:0]  div_q = 7'h00;
  logic        oscTick, cycleTick, cpuTick, periphTick, pllActive, pinClk;
  integer      seed = 32'hd61c;
  int          n_errors = 0, num_checks = 0, cycles = 0, nOsc, nCyc, nCpu;
  // Per case: source code, oscillator index, multiplier, oscillator ticks in 2048 cycles
  localparam logic [2:0] MCODE [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h3};
  localparam logic [2:0] MOSC [9] = '{3'h0, 3'h0, 3'h3, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0, 3'h3};
  localparam logic       MPLL [9] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  localparam int         MTICK [9] = '{128, 512, 64, 256, 16, 32, 8, 128, 256};
  // Divisor register writes and the value read back after each
  localparam logic [15:0] WSEQ [7] = '{16'h3800, 16'h5800, 16'h0000, 16'h0000,
    16'h0800, 16'h2000, 16'hA800};
  localparam logic [15:0] RSEQ [7] = '{16'h3800, 16'h3800, 16'h3000, 16'h0000,
    16'h0000, 16'h2000, 16'hA800};

  oscd_top dut (
    .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .newSourceSelect(src), .primarySourceMode(pm),
    .oscPinFunctionFuse(pinFuse), .fusesErased(erased), .fastRcTick(div_q[3]),
    .lowPowerRcTick(div_q[5]), .secondaryTick(div_q[6]), .primaryTick(div_q[4]),
    .interruptReq(irq),
    .oscTick(oscTick), .cycleTick(cycleTick), .cpuTick(cpuTick), .periphTick(periphTick),
    .pllActive(pllActive), .secondPinIsClock(pinClk), .activeOscillator(actOsc));

  // ----------------------------------------------------------------
  // Clock, source oscillators and the output watcher
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  // Sources stay slower than an eighth of clk so the synchronisers see every edge
  always @(posedge clk) div_q <= div_q + 7'h01;
  // Read data are taken from the queue in the one cycle they stand
  always @(posedge clk) begin
    cycles++;
    rdPend <= rdStb;
    if (rdPend) check(rdData, expQ.pop_front(), 0);
    nOsc += oscTick;
    nCyc += cycleTick;
    nCpu += cpuTick;
    if (cycles == 95000) begin
      n_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input int tol);
    logic bad;
    num_checks++;
    bad = (seen !== exp);
    if (!$isunknown(seen) && (seen > exp ? seen - exp : exp - seen) <= tol) bad = 1'b0;
    if (bad) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus cycle; a read leaves its expected data in the queue
  task automatic op(input logic w, input logic [3:0] a, input logic [15:0] d,
                    input logic [15:0] e);
    @(posedge clk);
    wrStb <= w;
    rdStb <= ~w;
    addr <= a;
    wrData <= d;
    if (!w) expQ.push_back(e);
  endtask
  task automatic idle;
    @(posedge clk);
    wrStb <= 1'b0;
    rdStb <= 1'b0;
  endtask
  // Fuses change only under reset and at a clock edge, so the checker never sees a stale mode
  task automatic setMode(input logic [2:0] s, input logic [1:0] p, input logic e);
    @(posedge clk);
    rst <= 1'b1;
    src <= s;
    pm <= p;
    erased <= e;
    pinFuse <= 1'($random(seed));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic irqPulse;
    irq <= 1'b1;
    repeat (4) @(posedge clk);
    irq <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Counters are cleared off the edge so the watcher never races the clear
  task automatic measure(input int n);
    #1;
    nOsc = 0;
    nCyc = 0;
    nCpu = 0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    setMode(3'h0, 2'h1, 1'b0);
    op(1'b0, 4'h0, 16'h0000, 16'h3000);
    for (int k = 0; k < 7; k++) begin
      op(1'b1, 4'h0, WSEQ[k] | 16'($random(seed) & 255), 16'h0000);
      op(1'b0, 4'h0, 16'h0000, RSEQ[k]);
    end
    op(1'b1, 4'h1, 16'hFFFF, 16'h0000);
    op(1'b0, 4'h1, 16'h0000, {9'h000, 1'b0, pinFuse, 2'h1, 3'h0});
    op(1'b0, 4'h5, 16'h0000, 16'h0000);
    idle();
    irqPulse();
    op(1'b0, 4'h0, 16'h0000, 16'hA000);
    op(1'b1, 4'h0, 16'h2800, 16'h0000);
    idle();
    irqPulse();
    op(1'b0, 4'h0, 16'h0000, 16'h2800);
    idle();
    $display("test registers done");
    for (int k = 0; k < 9; k++) begin
      setMode(MCODE[k], k < 8 ? 2'h1 : 2'h0, 1'b0);
      op(1'b0, 4'h2, 16'h0000, {11'h000, MPLL[k], 1'b0, MOSC[k]});
      idle();
      measure(2048);
      check(16'(nOsc), 16'(MTICK[k]), 4);
      check(16'(nCyc), 16'(MTICK[k] / 2), 2);
      check(16'(nCpu), 16'(MTICK[k] / 2), 2);
      check({12'h000, pllActive, actOsc}, {12'h000, MPLL[k], MOSC[k]}, 0);
      check({15'h0000, pinClk}, {15'h0000, (k == 2 || k == 3) ? 1'b1 : pinFuse}, 0);
    end
    setMode(3'h3, 2'h1, 1'b1);
    op(1'b0, 4'h2, 16'h0000, 16'h0000);
    op(1'b0, 4'h1, 16'h0000, {9'h000, 1'b1, pinFuse, 2'h1, 3'h3});
    idle();
    $display("test sources done");
    setMode(3'h7, 2'h1, 1'b0);
    for (int k = 0; k < 8; k++) begin
      op(1'b1, 4'h0, {5'h03, 3'(k), 8'h00}, 16'h0000);
      op(1'b0, 4'h0, 16'h0000, {5'h03, 3'(k), 8'h00});
      idle();
      measure(k == 7 ? 64 << 8 : 64 << k); // Top code divides by 256, not 128
      check(16'(nOsc), 16'h0004, 1);
    end
    $display("test postscaler done");
    setMode(3'h0, 2'h1, 1'b0);
    for (int k = 0; k < 8; k++) begin
      op(1'b1, 4'h0, 16'h0000, 16'h0000);
      op(1'b1, 4'h0, {1'b0, 3'(k), 12'h000}, 16'h0000);
      op(1'b1, 4'h0, {1'b0, 3'(k), 1'b1, 11'h000}, 16'h0000);
      op(1'b0, 4'h0, 16'h0000, k == 0 ? 16'h0000 : {1'b0, 3'(k), 1'b1, 11'h000});
      idle();
      measure(128 << k);
      check(16'(nCyc), 16'(4 << k), 1);
      check(16'(nCpu), 16'h0004, 1);
    end
    $display("test reduction done");
    conclude();
  end
endmodule
